// [src/rmci_pkg.sv]
// Constants, command codes and state types of the repeater management interpreter
package rmci_pkg;
	// ********************************
	// Timing
	// ********************************
	localparam int CLK_MHZ      = 100;
	localparam int BIT_TIME_NS  = 100;
	localparam int BIT_CYC      = BIT_TIME_NS * CLK_MHZ / 1000;
	localparam int ACT_SLOTS    = 10;              // Sample period in bit times
	localparam int ACT_PERIOD_NS = ACT_SLOTS * BIT_TIME_NS;
	localparam int TP_PORTS     = 8;
	localparam int ACT_BITS     = TP_PORTS + 1;    // AUI in bit 0
	localparam int FRAME_BITS   = 9;               // Start bit plus eight data
	localparam int LOOP_ZEROS   = 3;
	localparam int CMD_FIFO_DEPTH = 16;

	// ********************************
	// Command codes
	// ********************************
	localparam logic [7:0] CMD_AUI_DIS   = 8'h2F;
	localparam logic [7:0] CMD_AUI_EN    = 8'h3F;
	localparam logic [7:0] CMD_AUI_PART  = 8'h8F;
	localparam logic [7:0] CMD_TP_PART   = 8'h80;
	localparam logic [7:0] CMD_AUI_ALT   = 8'h1F;
	localparam logic [7:0] CMD_TP_ALT    = 8'h10;
	localparam logic [7:0] CMD_LINK_STAT = 8'hD0;
	localparam logic [7:0] CMD_POL_STAT  = 8'hE0;
	localparam logic [4:0] CMD_TP_DIS    = 5'h04;  // Upper five bits, port in [2:0]
	localparam logic [4:0] CMD_TP_EN     = 5'h06;
	localparam logic [4:0] CMD_LT_DIS    = 5'h08;
	localparam logic [4:0] CMD_LT_EN     = 5'h0A;
	localparam logic [4:0] CMD_POL_DIS   = 5'h0C;
	localparam logic [4:0] CMD_POL_EN    = 5'h0E;

	// ********************************
	// Reset values
	// ********************************
	localparam logic       RST_AUI_EN  = 1'h1;
	localparam logic [7:0] RST_TP_EN   = 8'hFF;
	localparam logic [7:0] RST_LT_EN   = 8'hFF;
	localparam logic [7:0] RST_POL_EN  = 8'hFF;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b01,
		RX_DATA = 2'b10
	} rmci_rx_t;
endpackage

// [src/rmci_top.sv]
// Command FIFO and serial management command interpreter of the repeater
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Commands are accepted only while the test-select pin is low.
// - Each byte is framed as one start bit and eight data bits.
// - Serial input and output both act on the serial clock rising edge.
// - Bytes move least significant bit first.
// - Command 2F disables the AUI port and idles its partition machine.
// - Command 3F re-enables the AUI port.
// - Command 00100bbb disables a TP port, forcing link fail and partition idle.
// - Command 00110bbb re-enables a TP port.
// - Command 8F returns AUI connected flag in the top bit, others zero.
// - Command 80 returns per-port TP connected flags.
// - Disabled ports report connected.
// - Command 1F sets AUI transmit-only reconnection until reset.
// - Command 10 sets all TP ports transmit-only reconnection until reset.
// - Command D0 returns link pass flags; disabled ports read pass.
// - Re-enabling a disabled TP port forces it into link fail.
// - Command 01000bbb disables link test on a port; it then reads pass.
// - Command 01010bbb re-enables link test only if it was disabled.
// - Command E0 returns reversed polarity only where correction is enabled.
// - Command 01110bbb enables automatic polarity correction on a port.
// - Command 01100bbb disables automatic polarity correction on a port.
// - Carrier states go out serially on activity output with a strobe.
// - Sample period is ten bit times; short carriers are latched.
// - Loopback passes each port's received data to its own transmitter.
// - Test-select low leaves loopback mode.

// ****************************************
// Command FIFO
// ****************************************
module rmci_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             core_clk,
	input  wire logic             reset,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire              empty = (wr_q == rd_q);
	wire              push  = in_valid && !full;
	wire              pop   = out_ready && !empty;

	// Handshake flags straight from the pointers
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_q[AW-1:0]];

	// Storage write, no reset needed on the data itself
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// Pointers with a wrap bit tell full from empty
	always_ff @(posedge core_clk) begin
		if (reset) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end
endmodule

// ****************************************
// Interpreter
// ****************************************
module rmci_top
	import rmci_pkg::*;
#(
	parameter int FIFO_DEPTH = CMD_FIFO_DEPTH
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       test_sel,
	input  wire logic       mgmt_sclk,
	input  wire logic       mgmt_si,
	output logic            mgmt_so,
	input  wire logic       aui_part_conn,
	input  wire logic [7:0] tp_part_conn,
	input  wire logic [7:0] tp_link_pass,
	input  wire logic [7:0] tp_pol_rev,
	input  wire logic       aui_crs,
	input  wire logic [7:0] tp_crs,
	output logic            aui_enable,
	output logic [7:0]      tp_enable,
	output logic            aui_part_idle,
	output logic [7:0]      tp_part_idle,
	output logic [7:0]      tp_link_fail,
	output logic            aui_alt_reconn,
	output logic            tp_alt_reconn,
	output logic [7:0]      tp_link_test_en,
	output logic [7:0]      tp_pol_corr_en,
	output logic            loopback_en,
	output logic            activity_serial_out,
	output logic            activity_strobe
);
	// ********************************
	// Pin synchronisers
	// ********************************
	logic [2:0] pin_s1_q;
	logic [2:0] pin_s2_q;
	logic       sclk_d_q;
	wire        test_s     = pin_s2_q[2];
	wire        sclk_s     = pin_s2_q[1];
	wire        si_s       = pin_s2_q[0];
	wire        sclk_rise  = sclk_s && !sclk_d_q;

	// Two stages per pin, then an edge detector on the clean copy
	always_ff @(posedge core_clk) begin
		if (reset) begin
			pin_s1_q <= 3'h1;
			pin_s2_q <= 3'h1;
			sclk_d_q <= 1'h0;
		end else begin
			pin_s1_q <= {test_sel, mgmt_sclk, mgmt_si};
			pin_s2_q <= pin_s1_q;
			sclk_d_q <= sclk_s;
		end
	end

	// ********************************
	// Serial receiver
	// ********************************
	rmci_rx_t   rx_state_q;
	logic [7:0] rx_sh_q;
	logic [2:0] rx_cnt_q;
	logic       rx_push_q;
	logic       fifo_in_ready;
	wire        rx_edge  = sclk_rise && !test_s;
	wire        rx_start = rx_edge && (rx_state_q == RX_IDLE) && !si_s && fifo_in_ready;

	// A full FIFO holds off the next start bit rather than losing a byte
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rx_state_q <= RX_IDLE;
			rx_sh_q    <= 8'h00;
			rx_cnt_q   <= 3'h0;
			rx_push_q  <= 1'h0;
		end else begin
			rx_push_q <= 1'h0;
			case (rx_state_q)
				RX_IDLE: begin
					rx_cnt_q <= 3'h0;
					if (rx_start) rx_state_q <= RX_DATA;
				end
				RX_DATA: begin
					if (rx_edge) begin
						rx_sh_q  <= {si_s, rx_sh_q[7:1]};
						rx_cnt_q <= rx_cnt_q + 3'h1;
						if (rx_cnt_q == 3'h7) begin
							rx_push_q  <= 1'h1;
							rx_state_q <= RX_IDLE;
						end
					end
				end
				default: rx_state_q <= RX_IDLE;
			endcase
		end
	end

	// ********************************
	// Command decode
	// ********************************
	logic       cmd_valid;
	logic [7:0] cmd;
	logic       tx_busy_q;
	wire        pop        = cmd_valid && !tx_busy_q;
	wire [7:0]  sel        = 8'h01 << cmd[2:0];
	wire [4:0]  hi         = cmd[7:3];
	wire        is_aui_dis = cmd == CMD_AUI_DIS;
	wire        is_aui_en  = cmd == CMD_AUI_EN;
	wire        is_aui_pt  = cmd == CMD_AUI_PART;
	wire        is_tp_pt   = cmd == CMD_TP_PART;
	wire        is_aui_alt = cmd == CMD_AUI_ALT;
	wire        is_tp_alt  = cmd == CMD_TP_ALT;
	wire        is_lnk_st  = cmd == CMD_LINK_STAT;
	wire        is_pol_st  = cmd == CMD_POL_STAT;
	wire        is_tp_dis  = hi == CMD_TP_DIS;
	wire        is_tp_en   = hi == CMD_TP_EN;
	wire        is_lt_dis  = hi == CMD_LT_DIS;
	wire        is_lt_en   = hi == CMD_LT_EN;
	wire        is_pol_dis = hi == CMD_POL_DIS;
	wire        is_pol_en  = hi == CMD_POL_EN;
	wire        has_resp   = is_aui_pt || is_tp_pt || is_lnk_st || is_pol_st;
	wire        known      = has_resp || is_aui_dis || is_aui_en || is_aui_alt || is_tp_alt
	                         || is_tp_dis || is_tp_en || is_lt_dis || is_lt_en
	                         || is_pol_dis || is_pol_en;

	rmci_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (rx_push_q),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_sh_q),
		.out_valid (cmd_valid),
		.out_ready (!tx_busy_q),
		.out_data  (cmd)
	);

	// ********************************
	// Port control state
	// ********************************
	logic       aui_en_q;
	logic [7:0] tp_en_q;
	logic       aui_alt_q;
	logic       tp_alt_q;
	logic [7:0] lt_en_q;
	logic [7:0] pol_en_q;
	logic       aui_idle_q;
	logic [7:0] tp_idle_q;
	logic [7:0] lfail_q;

	// Status bytes; disabled ports read connected and link pass
	wire [7:0] part_byte = tp_part_conn | ~tp_en_q;
	wire       aui_bit   = aui_part_conn || !aui_en_q;
	wire [7:0] link_byte = tp_link_pass | ~tp_en_q | ~lt_en_q;
	wire [7:0] pol_byte  = tp_pol_rev & pol_en_q;
	wire [7:0] resp_byte = is_aui_pt ? {aui_bit, 7'h00} :
	                       is_tp_pt  ? part_byte :
	                       is_lnk_st ? link_byte : pol_byte;
	wire [7:0] reen      = sel & ~tp_en_q;

	// Enables and algorithm selects; force lines are one-cycle pulses
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aui_en_q   <= RST_AUI_EN;
			tp_en_q    <= RST_TP_EN;
			aui_alt_q  <= 1'h0;
			tp_alt_q   <= 1'h0;
			lt_en_q    <= RST_LT_EN;
			pol_en_q   <= RST_POL_EN;
			aui_idle_q <= 1'h0;
			tp_idle_q  <= 8'h00;
			lfail_q    <= 8'h00;
		end else begin
			aui_idle_q <= pop && is_aui_dis;
			tp_idle_q  <= (pop && is_tp_dis) ? sel : 8'h00;
			lfail_q    <= !pop ? 8'h00 : is_tp_dis ? sel : is_tp_en ? reen : 8'h00;
			if (pop) begin
				if (is_aui_dis) aui_en_q <= 1'h0;
				if (is_aui_en) aui_en_q <= 1'h1;
				if (is_tp_dis) tp_en_q <= tp_en_q & ~sel;
				if (is_tp_en) tp_en_q <= tp_en_q | sel;
				if (is_aui_alt) aui_alt_q <= 1'h1;
				if (is_tp_alt) tp_alt_q <= 1'h1;
				if (is_lt_dis) lt_en_q <= lt_en_q & ~sel;
				if (is_lt_en) lt_en_q <= lt_en_q | (sel & ~lt_en_q);
				if (is_pol_en) pol_en_q <= pol_en_q | sel;
				if (is_pol_dis) pol_en_q <= pol_en_q & ~sel;
			end
		end
	end

	assign aui_enable      = aui_en_q;
	assign tp_enable       = tp_en_q;
	assign aui_part_idle   = aui_idle_q;
	assign tp_part_idle    = tp_idle_q;
	assign tp_link_fail    = lfail_q;
	assign aui_alt_reconn  = aui_alt_q;
	assign tp_alt_reconn   = tp_alt_q;
	assign tp_link_test_en = lt_en_q;
	assign tp_pol_corr_en  = pol_en_q;

	// ********************************
	// Serial transmitter
	// ********************************
	logic [8:0] tx_sh_q;
	logic [3:0] tx_cnt_q;
	logic       so_q;

	// Start bit then data, one bit per serial clock rise; the host must
	// keep clocking after the command so the answer can drain
	always_ff @(posedge core_clk) begin
		if (reset) begin
			tx_sh_q   <= 9'h1FF;
			tx_cnt_q  <= 4'h0;
			tx_busy_q <= 1'h0;
			so_q      <= 1'h1;
		end else if (pop && has_resp) begin
			tx_sh_q   <= {resp_byte, 1'b0};
			tx_cnt_q  <= 4'(FRAME_BITS);
			tx_busy_q <= 1'h1;
		end else if (sclk_rise && tx_busy_q) begin
			so_q      <= tx_sh_q[0];
			tx_sh_q   <= {1'b1, tx_sh_q[8:1]};
			tx_cnt_q  <= tx_cnt_q - 4'h1;
			tx_busy_q <= tx_cnt_q != 4'h1;
		end else if (sclk_rise) begin
			so_q      <= 1'h1;
		end
	end

	assign mgmt_so = so_q;

	// ********************************
	// Loopback entry
	// ********************************
	logic [1:0] zero_cnt_q;
	logic       loop_q;

	// Consecutive zeros while test-select is high; any one resets the count
	always_ff @(posedge core_clk) begin
		if (reset || !test_s) begin
			zero_cnt_q <= 2'h0;
			loop_q     <= 1'h0;
		end else if (sclk_rise) begin
			zero_cnt_q <= si_s ? 2'h0 : (zero_cnt_q == 2'(LOOP_ZEROS) ? zero_cnt_q : zero_cnt_q + 2'h1);
			if (!si_s && zero_cnt_q == 2'(LOOP_ZEROS - 1)) loop_q <= 1'h1;
		end
	end

	// The analog receive-to-transmit path is switched by this level
	assign loopback_en = loop_q;

	// ********************************
	// Activity monitor
	// ********************************
	localparam int CW = $clog2(BIT_CYC);
	logic [CW-1:0]       cyc_q;
	logic [3:0]          slot_q;
	logic [ACT_BITS-1:0] acc_q;
	logic [ACT_BITS-1:0] snap_q;
	logic                act_q;
	logic                stb_q;
	wire                 bit_en  = cyc_q == CW'(BIT_CYC - 1);
	wire                 last    = slot_q == 4'(ACT_SLOTS - 1);
	wire [ACT_BITS-1:0]  crs_vec = {tp_crs, aui_crs};

	// Short carrier pulses stay in the accumulator until sampled; a new
	// carrier in the sampling cycle is kept for the next period
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cyc_q  <= '0;
			slot_q <= 4'h0;
			acc_q  <= '0;
			snap_q <= '0;
			act_q  <= 1'h0;
			stb_q  <= 1'h0;
		end else begin
			cyc_q <= bit_en ? '0 : cyc_q + 1'b1;
			acc_q <= crs_vec | ((bit_en && last) ? '0 : acc_q);
			if (bit_en) begin
				slot_q <= last ? 4'h0 : slot_q + 4'h1;
				stb_q  <= last;
				act_q  <= last ? 1'h0 : snap_q[slot_q];
				if (last) snap_q <= acc_q | crs_vec;
			end
		end
	end

	assign activity_serial_out = act_q;
	assign activity_strobe     = stb_q;

	// ********************************
	// Assertions
	// ********************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	chk_rx_test_gate: assert property (test_s && rx_state_q == RX_IDLE |=> rx_state_q == RX_IDLE)
		else $error("receiver started while test select high");
	chk_tx_frame: assert property (pop && has_resp |=> tx_cnt_q == 4'h9 && !tx_sh_q[0])
		else $error("answer frame not loaded with start bit");
	chk_so_edge: assert property ($changed(so_q) |-> $past(sclk_rise))
		else $error("serial output moved without clock rise");
	chk_tx_lsb: assert property (tx_busy_q && sclk_rise && !pop |=> so_q == $past(tx_sh_q[0]))
		else $error("serial output not least bit first");
	chk_aui_disable: assert property (pop && is_aui_dis |=> !aui_en_q && aui_idle_q)
		else $error("AUI disable failed");
	chk_tp_disable: assert property (pop && is_tp_dis |=> (tp_en_q & lfail_q) == 8'h00 && lfail_q != 8'h00)
		else $error("TP disable failed");
	chk_reen_lfail: assert property (pop && is_tp_en && reen != 8'h00 |=> lfail_q == $past(reen))
		else $error("re-enabled port not forced to link fail");
	chk_aui_part: assert property (pop && is_aui_pt |=> tx_sh_q[8] == $past(aui_bit) && tx_sh_q[7:1] == 7'h00)
		else $error("AUI partition byte wrong");
	chk_alt_hold: assert property (aui_alt_q |=> aui_alt_q)
		else $error("alternate algorithm dropped without reset");
	chk_loop_exit: assert property (!test_s |=> !loop_q)
		else $error("loopback held with test select low");
	chk_unknown_cmd: assert property (pop && !known |=> !tx_busy_q && $stable(tp_en_q) && $stable(aui_en_q))
		else $error("unknown command had an effect");
	chk_strobe_pulse: assert property ($rose(stb_q) |-> stb_q [*8] ##1 stb_q ##1 stb_q ##1 !stb_q)
		else $error("strobe width not one bit time");

	cov_resp_cmd: cover property (pop && is_tp_pt ##[1:200] !tx_busy_q);
	cov_loop_in: cover property ($rose(loop_q));
	cov_act_bit: cover property (stb_q && snap_q != '0);
endmodule

`default_nettype wire

// [tb/rmci_host.sv]
// Host management controller model that drives the serial command link
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Host model
// ****************************************
module rmci_host (
	input  wire logic core_clk,
	output logic      mgmt_sclk,
	output logic      mgmt_si,
	input  wire logic mgmt_so
);
	// Clock parked low and data at the mark level between frames
	initial begin
		mgmt_sclk = 1'b0;
		mgmt_si   = 1'b1;
	end

	// One bit: data set while the clock is low and held across the rise.
	// The answer is read late in the high phase, after the receiver's sync delay.
	task automatic tick(input logic din, output logic seen);
		@(posedge core_clk);
		mgmt_sclk <= 1'b0;
		mgmt_si   <= din;
		repeat (8) @(posedge core_clk);
		mgmt_sclk <= 1'b1;
		repeat (8) @(negedge core_clk);
		seen = mgmt_so;
	endtask

	// Clock stands still between frames
	task automatic park();
		@(posedge core_clk);
		mgmt_sclk <= 1'b0;
		mgmt_si   <= 1'b1;
	endtask

	// Command frame only; the serial output seen at each rise is kept
	task automatic send(input logic [7:0] cmd, output logic [8:0] seen);
		logic b;
		tick(1'b0, b);
		seen[0] = b;
		for (int i = 0; i < 8; i++) begin
			tick(cmd[i], b);
			seen[i + 1] = b;
		end
	endtask

	// Command frame, then enough clocks for a full answer byte
	task automatic xfer(input logic [7:0] cmd, output logic start, output logic [7:0] resp);
		logic       s;
		logic [8:0] f;
		send(cmd, f);
		tick(1'b1, start);
		for (int i = 0; i < 8; i++) begin
			tick(1'b1, resp[i]);
		end
		tick(1'b1, s);
		park();
	endtask

	// Zeros clocked in while test-select is high
	task automatic zeros(input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			tick(1'b0, s);
		end
		park();
	endtask
endmodule

`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the repeater management interpreter and its FIFO
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench top
// ****************************************
module tb_top
	import rmci_pkg::*;
;
	typedef struct packed {
		logic [7:0] cmd;
		logic       start;
		logic [7:0] resp;
		logic       aui_en;
		logic [7:0] tp_en;
		logic [7:0] lt_en;
		logic [7:0] pol_en;
		logic [1:0] alt;
	} rmci_row_t;

	logic       core_clk, reset, test_sel, mgmt_sclk, mgmt_si, mgmt_so;
	logic       aui_part_conn, aui_crs, aui_enable, aui_part_idle;
	logic       aui_alt_reconn, tp_alt_reconn, loopback_en;
	logic       activity_serial_out, activity_strobe;
	logic [7:0] tp_part_conn, tp_link_pass, tp_pol_rev, tp_crs, tp_enable;
	logic [7:0] tp_part_idle, tp_link_fail, tp_link_test_en, tp_pol_corr_en;
	int         miscompares, cmp_count, n_aui_idle, n_tp_idle, n_link_fail;
	rmci_row_t  rows [20];

	rmci_top DUT (
		.core_clk, .reset, .test_sel, .mgmt_sclk, .mgmt_si, .mgmt_so,
		.aui_part_conn, .tp_part_conn, .tp_link_pass, .tp_pol_rev, .aui_crs, .tp_crs,
		.aui_enable, .tp_enable, .aui_part_idle, .tp_part_idle, .tp_link_fail,
		.aui_alt_reconn, .tp_alt_reconn, .tp_link_test_en, .tp_pol_corr_en,
		.loopback_en, .activity_serial_out, .activity_strobe
	);

	rmci_host host (.core_clk, .mgmt_sclk, .mgmt_si, .mgmt_so);

	// Free-running core clock, 10 ns period
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Count force pulses; sampled on the falling edge to stay clear of updates
	always @(negedge core_clk) begin
		if (aui_part_idle === 1'b1) n_aui_idle++;
		if (tp_part_idle[2] === 1'b1) n_tp_idle++;
		if (tp_link_fail[2] === 1'b1) n_link_fail++;
	end

	// Watchdog: about four times what the whole run needs
	initial begin
		#300000;
		miscompares++;
		print_verdict();
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Bounded wait for the activity strobe to reach a level
	task automatic wait_strobe(input logic lvl);
		int n;
		n = 0;
		while (activity_strobe !== lvl && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		check("strobe_wait", 16'(activity_strobe), 16'(lvl));
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Command table: command, start bit, answer, then expected controls
	// ****************************************
	initial begin
		rows = '{
			{CMD_AUI_PART,       1'h0, 8'h00, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_TP_PART,        1'h0, 8'h5A, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_POL_STAT,       1'h0, 8'hC3, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_AUI_DIS,        1'h1, 8'hFF, 1'h0, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_AUI_PART,       1'h0, 8'h80, 1'h0, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_AUI_EN,         1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_TP_DIS, 3'h2,   1'h1, 8'hFF, 1'h1, 8'hFB, 8'hFF, 8'hFF, 2'h0},
			{CMD_TP_PART,        1'h0, 8'h5E, 1'h1, 8'hFB, 8'hFF, 8'hFF, 2'h0},
			{CMD_LINK_STAT,      1'h0, 8'h37, 1'h1, 8'hFB, 8'hFF, 8'hFF, 2'h0},
			{CMD_TP_EN, 3'h2,    1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_LT_DIS, 3'h7,   1'h1, 8'hFF, 1'h1, 8'hFF, 8'h7F, 8'hFF, 2'h0},
			{CMD_LINK_STAT,      1'h0, 8'hB3, 1'h1, 8'hFF, 8'h7F, 8'hFF, 2'h0},
			{CMD_LT_EN, 3'h7,    1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_LT_EN, 3'h1,    1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_POL_DIS, 3'h0,  1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFE, 2'h0},
			{CMD_POL_STAT,       1'h0, 8'hC2, 1'h1, 8'hFF, 8'hFF, 8'hFE, 2'h0},
			{CMD_POL_EN, 3'h0,   1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h0},
			{CMD_AUI_ALT,        1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h2},
			{CMD_TP_ALT,         1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h3},
			{8'hAA,              1'h1, 8'hFF, 1'h1, 8'hFF, 8'hFF, 8'hFF, 2'h3}
		};
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic       st;
		logic [7:0] rs;
		logic [8:0] act;
		logic [8:0] fr;
		int         hi;
		reset = 1'b1;
		test_sel = 1'b0;
		aui_part_conn = 1'b0;
		tp_part_conn = 8'h5A;
		tp_link_pass = 8'h33;
		tp_pol_rev = 8'hC3;
		aui_crs = 1'b0;
		tp_crs = 8'h00;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
		// Status inputs stay fixed, so every answer follows from the table
		for (int i = 0; i < 20; i++) begin
			host.xfer(rows[i].cmd, st, rs);
			repeat (4) @(negedge core_clk);
			check("start_bit", 16'(st), 16'(rows[i].start));
			check("answer", 16'(rs), 16'(rows[i].resp));
			check("aui_enable", 16'(aui_enable), 16'(rows[i].aui_en));
			check("tp_enable", 16'(tp_enable), 16'(rows[i].tp_en));
			check("link_test_en", 16'(tp_link_test_en), 16'(rows[i].lt_en));
			check("pol_corr_en", 16'(tp_pol_corr_en), 16'(rows[i].pol_en));
			check("alt_reconn", 16'({aui_alt_reconn, tp_alt_reconn}), 16'(rows[i].alt));
		end
		check("aui_idle_pulses", 16'(n_aui_idle), 16'h0001);
		check("tp_idle_pulses", 16'(n_tp_idle), 16'h0001);
		check("link_fail_pulses", 16'(n_link_fail), 16'h0002);
		$display("test command_table done");
		// Only a reset brings back the standard reconnection algorithm
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(negedge core_clk);
		check("alt_after_reset", 16'({aui_alt_reconn, tp_alt_reconn}), 16'h0000);
		check("en_after_reset", 16'({aui_enable, tp_enable}), 16'h01FF);
		check("so_idle", 16'(mgmt_so), 16'h0001);
		$display("test mid_run_reset done");
		// Two zeros are not enough; the third enters loopback, commands are ignored
		@(posedge core_clk);
		test_sel <= 1'b1;
		repeat (4) @(posedge core_clk);
		host.zeros(2);
		@(negedge core_clk);
		check("loop_two_zeros", 16'(loopback_en), 16'h0000);
		host.zeros(1);
		repeat (6) @(negedge core_clk);
		check("loop_three_zeros", 16'(loopback_en), 16'h0001);
		host.xfer(CMD_AUI_DIS, st, rs);
		repeat (6) @(negedge core_clk);
		check("cmd_in_test_mode", 16'(aui_enable), 16'h0001);
		@(posedge core_clk);
		test_sel <= 1'b0;
		// Two sync stages plus the register: low from the third edge on
		repeat (4) @(negedge core_clk);
		check("loop_exit", 16'(loopback_en), 16'h0000);
		$display("test loopback done");
		// A carrier burst far shorter than a sample period must still be reported
		wait_strobe(1'b1);
		wait_strobe(1'b0);
		@(posedge core_clk);
		tp_crs <= 8'h08;
		repeat (3) @(posedge core_clk);
		tp_crs <= 8'h00;
		wait_strobe(1'b1);
		hi = 0;
		while (activity_strobe === 1'b1 && hi < 50) begin
			@(negedge core_clk);
			hi++;
		end
		check("strobe_width", 16'(hi), 16'(BIT_CYC));
		repeat (4) @(negedge core_clk);
		for (int k = 0; k < ACT_BITS; k++) begin
			act[k] = activity_serial_out;
			repeat (BIT_CYC) @(negedge core_clk);
		end
		check("activity_bits", 16'(act), 16'h0010);
		$display("test activity done");
		// Back-to-back frames through the command buffer: the second command is
		// framed while the first one's answer drains, and still takes effect
		host.send(CMD_TP_PART, fr);
		check("so_idle_frame", 16'(fr), 16'h01FF);
		host.send(CMD_AUI_DIS, fr);
		check("answer_during_cmd", 16'(fr), 16'h00B4);
		host.xfer(CMD_AUI_PART, st, rs);
		repeat (4) @(negedge core_clk);
		check("queued_aui_dis", 16'(aui_enable), 16'h0000);
		check("start_after_queue", 16'(st), 16'h0000);
		check("answer_after_queue", 16'(rs), 16'h0080);
		$display("test command_queue done");
		print_verdict();
	end
endmodule

`default_nettype wire
